// ==== inc/ghs_pkg.sv ====
// Constants, types and helpers shared by the gas heater sequencing block
package ghs_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_HEAT_RES_CORR   = 8'h00;
    localparam logic [7:0] ADDR_HEAT_RANGE_CAL  = 8'h02;
    localparam logic [7:0] ADDR_RANGE_SW_ERR    = 8'h04;
    localparam logic [7:0] ADDR_SETPOINT_BASE   = 8'h10;
    localparam logic [7:0] ADDR_DURATION_BASE   = 8'h20;
    localparam logic [7:0] ADDR_GAS_CTRL        = 8'h30;
    localparam logic [7:0] ADDR_MODE            = 8'h31;
    localparam logic [7:0] ADDR_STATUS          = 8'h32;
    localparam logic [7:0] ADDR_GAS_RES_MSB     = 8'h33;
    localparam logic [7:0] ADDR_GAS_RES_LSB     = 8'h34;
    localparam logic [7:0] ADDR_CAL_SECOND_LOW  = 8'hEB;
    localparam logic [7:0] ADDR_CAL_SECOND_HIGH = 8'hEC;
    localparam logic [7:0] ADDR_CAL_FIRST       = 8'hED;
    localparam logic [7:0] ADDR_CAL_THIRD       = 8'hEE;

    localparam int unsigned NUM_SLOTS = 10;
    localparam logic [3:0]  LAST_SLOT = 4'h9;

    // Field positions
    localparam int unsigned HEAT_RANGE_LSB   = 4;
    localparam int unsigned RANGE_SW_ERR_LSB = 4;
    localparam int unsigned GAS_RUN_BIT      = 4;
    localparam int unsigned MODE_FORCE_BIT   = 0;
    localparam int unsigned ST_NEW_BIT       = 7;
    localparam int unsigned ST_GAS_BUSY_BIT  = 6;
    localparam int unsigned ST_BUSY_BIT      = 5;
    localparam int unsigned RES_VALID_BIT    = 5;
    localparam int unsigned RES_STAB_BIT     = 4;
    localparam int unsigned DUR_MULT_LSB     = 6;

    // Reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [3:0]  RST_SLOT  = 4'h0;
    localparam logic [9:0]  RST_ADC   = 10'h000;
    localparam logic [3:0]  RST_RANGE = 4'h0;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned DUR_MIN_MS    = 1;
    localparam int unsigned DUR_MAX_MS    = 4032;
    localparam logic [11:0] DUR_MIN_CODE  = 12'(DUR_MIN_MS);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TPH,
        ST_HEAT,
        ST_GAS,
        ST_UPDATE
    } ghs_state_type;

    // Six-bit base times a multiplier of 1, 4, 16 or 64 milliseconds
    function automatic logic [11:0] dur_ms(input logic [7:0] code);
        logic [1:0] mult;
        mult = code[DUR_MULT_LSB +: 2];
        dur_ms = {6'h00, code[5:0]} << {mult, 1'b0};
    endfunction

    function automatic logic slot_hit(input logic [7:0] addr, input logic [7:0] base);
        slot_hit = (addr >= base) && (addr <= base + {4'h0, LAST_SLOT});
    endfunction

    function automatic logic [3:0] slot_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        slot_idx = diff[3:0];
    endfunction

endpackage

// ==== logic/ghs_gas_sequencer.sv ====
// Gas heater sequencing, heater regulation, gas readout and register file
// Behaviour
// RULE_01: Ten heater set-point slots, indexed 0 to 9, each hold an eight-bit target code.
// RULE_02: The heater loop regulates on the measured heater resistance against the target code.
// RULE_03: Heating starts only after the temperature, pressure and humidity conversions finish.
// RULE_04: Each slot has its own heating duration, programmable from 1 ms to 4032 ms.
// RULE_05: A fresh-result flag rises when a new result is ready, and the host polls it.
// RULE_06: With gas enabled the host checks gas-valid and heater-stable before using the gas result.
// RULE_07: Heater-stable is cleared when the plate did not reach its target by the end of heating.
// RULE_08: The gas ADC result and the gas range are exposed together for the host.
// RULE_09: A signed four-bit range-switching error sits in the upper nibble of byte 0x04.
// RULE_10: The two-bit heater range calibration sits in bits 5 and 4 of byte 0x02.
// RULE_11: A signed eight-bit heater resistance correction is readable at byte 0x00.
// RULE_12: The heater calibration bytes are read-only at 0xED, 0xEB and 0xEC, and 0xEE.
// RULE_13: The host picks the heater slot with the slot-select field and enables gas with the gas-run bit.
// RULE_14: After heating the gas layer is measured and result, range and flags update before fresh-result.
// RULE_15: The duration counter starts with heating and ends it exactly at the slot's duration.
`timescale 1ns/100ps
`default_nettype none

module ghs_gas_sequencer #(
    parameter int unsigned CYC_PER_MS     = ghs_pkg::CYC_PER_MS,
    parameter logic [7:0]  HEAT_RES_CORR  = 8'hF6,   // Arbitrary trim value
    parameter logic [1:0]  HEAT_RANGE_CAL = 2'h1,    // Arbitrary trim value
    parameter logic [3:0]  RANGE_SW_ERR   = 4'hE,    // Arbitrary trim value
    parameter logic [7:0]  CAL_FIRST      = 8'h9A,   // Arbitrary trim value
    parameter logic [15:0] CAL_SECOND     = 16'hD1C3, // Arbitrary trim value
    parameter logic [7:0]  CAL_THIRD      = 8'h12    // Arbitrary trim value
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            tph_start_o,
    input  wire logic       tph_done_i,
    output logic            heater_en_o,
    output logic            heater_drive_o,
    output logic      [7:0] heater_target_o,
    input  wire logic [7:0] heater_res_i,
    output logic            gas_start_o,
    input  wire logic       gas_done_i,
    input  wire logic [9:0] gas_adc_i,
    input  wire logic [3:0] gas_range_i,
    output logic            new_data_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    if (CYC_PER_MS < 1) begin : g_chk_rate
        $error("CYC_PER_MS must be at least one");
    end

    if (ghs_pkg::NUM_SLOTS > 16) begin : g_chk_slots
        $error("slot index is four bits wide");
    end

    // Out-of-range slot numbers fall back to the last slot so the arrays are never overrun
    function automatic logic [3:0] clamp_slot(input logic [3:0] idx);
        clamp_slot = (idx > ghs_pkg::LAST_SLOT) ? ghs_pkg::LAST_SLOT : idx;
    endfunction

    // Host settings
    logic [7:0]  sp_ff  [ghs_pkg::NUM_SLOTS];
    logic [7:0]  dur_ff [ghs_pkg::NUM_SLOTS];
    logic [3:0]  slot_sel_ff;
    logic        gas_run_ff;

    // Settings frozen for the running measurement
    logic [3:0]  slot_run_ff;
    logic        gas_run_run_ff;
    logic [7:0]  target_ff;

    // Results seen by the host
    logic [9:0]  gas_adc_ff;
    logic [3:0]  gas_range_ff;
    logic        gas_valid_ff;
    logic        heat_stab_ff;
    logic        stab_meas_ff;
    logic        new_data_ff;

    // Sequencer
    ghs_pkg::ghs_state_type state_ff;
    ghs_pkg::ghs_state_type nxt_state;
    logic        tph_start_ff;
    logic        gas_start_ff;
    logic        drive_ff;
    logic [7:0]  rdata_ff;

    // Heating timer
    logic        heat_busy;
    logic        heat_done;
    logic [11:0] heat_dur;

    // Decode
    logic        sp_sel;
    logic [3:0]  sp_idx;
    logic        dur_sel;
    logic [3:0]  dur_idx;
    logic        wr_sp;
    logic        wr_dur;
    logic        wr_ctrl;
    logic        wr_mode;
    logic        force_req;
    logic        meas_start;
    logic        heat_start;
    logic        heat_end;
    logic        gas_end;
    logic        below_target;
    logic        meas_busy;
    logic        gas_busy;

    // Read bytes
    logic [7:0]  range_cal_byte;
    logic [7:0]  sw_err_byte;
    logic [7:0]  ctrl_byte;
    logic [7:0]  status_byte;
    logic [7:0]  res_lsb_byte;
    logic [7:0]  rd_mux;

    assign sp_sel     = ghs_pkg::slot_hit(reg_addr_i, ghs_pkg::ADDR_SETPOINT_BASE);
    assign sp_idx     = ghs_pkg::slot_idx(reg_addr_i, ghs_pkg::ADDR_SETPOINT_BASE);
    assign dur_sel    = ghs_pkg::slot_hit(reg_addr_i, ghs_pkg::ADDR_DURATION_BASE);
    assign dur_idx    = ghs_pkg::slot_idx(reg_addr_i, ghs_pkg::ADDR_DURATION_BASE);
    assign wr_sp      = reg_wr_i && sp_sel;
    assign wr_dur     = reg_wr_i && dur_sel;
    assign wr_ctrl    = reg_wr_i && (reg_addr_i == ghs_pkg::ADDR_GAS_CTRL);
    assign wr_mode    = reg_wr_i && (reg_addr_i == ghs_pkg::ADDR_MODE);

    // A force request while a measurement runs is ignored
    assign force_req  = wr_mode && reg_wdata_i[ghs_pkg::MODE_FORCE_BIT];
    assign meas_start = force_req && (state_ff == ghs_pkg::ST_IDLE);

    // Heating only once the other conversions have reported done
    assign heat_start = (state_ff == ghs_pkg::ST_TPH) && tph_done_i && gas_run_run_ff; // RULE_03
    assign heat_end   = (state_ff == ghs_pkg::ST_HEAT) && heat_done;
    assign gas_end    = (state_ff == ghs_pkg::ST_GAS) && gas_done_i;

    // Regulation compares plate resistance with the resistance code
    assign below_target = heater_res_i < target_ff; // RULE_02

    assign heat_dur   = ghs_pkg::dur_ms(dur_ff[slot_run_ff]); // RULE_04
    assign meas_busy  = state_ff != ghs_pkg::ST_IDLE;
    assign gas_busy   = (state_ff == ghs_pkg::ST_HEAT) || (state_ff == ghs_pkg::ST_GAS);

    assign range_cal_byte = 8'(HEAT_RANGE_CAL) << ghs_pkg::HEAT_RANGE_LSB; // RULE_10
    assign sw_err_byte    = 8'(RANGE_SW_ERR) << ghs_pkg::RANGE_SW_ERR_LSB; // RULE_09

    always_comb begin
        ctrl_byte = ghs_pkg::RST_BYTE;
        ctrl_byte[3:0] = slot_sel_ff;
        ctrl_byte[ghs_pkg::GAS_RUN_BIT] = gas_run_ff;
    end

    always_comb begin
        status_byte = ghs_pkg::RST_BYTE;
        status_byte[ghs_pkg::ST_NEW_BIT] = new_data_ff; // RULE_05
        status_byte[ghs_pkg::ST_GAS_BUSY_BIT] = gas_busy;
        status_byte[ghs_pkg::ST_BUSY_BIT] = meas_busy;
    end

    // Low result byte carries the ADC tail, the flags and the range side by side
    always_comb begin
        res_lsb_byte = ghs_pkg::RST_BYTE;
        res_lsb_byte[7:6] = gas_adc_ff[1:0];
        res_lsb_byte[ghs_pkg::RES_VALID_BIT] = gas_valid_ff;
        res_lsb_byte[ghs_pkg::RES_STAB_BIT] = heat_stab_ff;
        res_lsb_byte[3:0] = gas_range_ff; // RULE_08
    end

    always_comb begin
        rd_mux = ghs_pkg::RST_BYTE;
        if (sp_sel) begin
            rd_mux = sp_ff[sp_idx];
        end else if (dur_sel) begin
            rd_mux = dur_ff[dur_idx];
        end else begin
            case (reg_addr_i)
                ghs_pkg::ADDR_HEAT_RES_CORR: begin
                    rd_mux = HEAT_RES_CORR; // RULE_11
                end
                ghs_pkg::ADDR_HEAT_RANGE_CAL: begin
                    rd_mux = range_cal_byte;
                end
                ghs_pkg::ADDR_RANGE_SW_ERR: begin
                    rd_mux = sw_err_byte;
                end
                ghs_pkg::ADDR_GAS_CTRL: begin
                    rd_mux = ctrl_byte;
                end
                ghs_pkg::ADDR_MODE: begin
                    rd_mux = {7'h00, meas_busy};
                end
                ghs_pkg::ADDR_STATUS: begin
                    rd_mux = status_byte;
                end
                ghs_pkg::ADDR_GAS_RES_MSB: begin
                    rd_mux = gas_adc_ff[9:2]; // RULE_08
                end
                ghs_pkg::ADDR_GAS_RES_LSB: begin
                    rd_mux = res_lsb_byte;
                end
                ghs_pkg::ADDR_CAL_SECOND_LOW: begin
                    rd_mux = CAL_SECOND[7:0]; // RULE_12
                end
                ghs_pkg::ADDR_CAL_SECOND_HIGH: begin
                    rd_mux = CAL_SECOND[15:8]; // RULE_12
                end
                ghs_pkg::ADDR_CAL_FIRST: begin
                    rd_mux = CAL_FIRST; // RULE_12
                end
                ghs_pkg::ADDR_CAL_THIRD: begin
                    rd_mux = CAL_THIRD; // RULE_12
                end
                default: begin
                    rd_mux = ghs_pkg::RST_BYTE;
                end
            endcase
        end
    end

    // Slot arrays; calibration bytes have no write path at all
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < ghs_pkg::NUM_SLOTS; i++) begin
                sp_ff[i]  <= ghs_pkg::RST_BYTE;
                dur_ff[i] <= ghs_pkg::RST_BYTE;
            end
        end else begin
            if (wr_sp) begin
                sp_ff[sp_idx] <= reg_wdata_i; // RULE_01
            end
            if (wr_dur) begin
                dur_ff[dur_idx] <= reg_wdata_i; // RULE_04
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_sel_ff <= ghs_pkg::RST_SLOT;
            gas_run_ff  <= 1'b0;
        end else if (wr_ctrl) begin
            slot_sel_ff <= clamp_slot(reg_wdata_i[3:0]);
            gas_run_ff  <= reg_wdata_i[ghs_pkg::GAS_RUN_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= ghs_pkg::RST_BYTE;
        end else if (reg_rd_i) begin
            rdata_ff <= rd_mux;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ghs_pkg::ST_IDLE: begin
                if (meas_start) begin
                    nxt_state = ghs_pkg::ST_TPH;
                end
            end
            ghs_pkg::ST_TPH: begin
                if (tph_done_i) begin
                    nxt_state = gas_run_run_ff ? ghs_pkg::ST_HEAT : ghs_pkg::ST_UPDATE; // RULE_03
                end
            end
            ghs_pkg::ST_HEAT: begin
                if (heat_done) begin
                    nxt_state = ghs_pkg::ST_GAS; // RULE_14
                end
            end
            ghs_pkg::ST_GAS: begin
                if (gas_done_i) begin
                    nxt_state = ghs_pkg::ST_UPDATE;
                end
            end
            ghs_pkg::ST_UPDATE: begin
                nxt_state = ghs_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = ghs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ghs_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Start pulses and the settings of the running measurement
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tph_start_ff   <= 1'b0;
            gas_start_ff   <= 1'b0;
            slot_run_ff    <= ghs_pkg::RST_SLOT;
            gas_run_run_ff <= 1'b0;
            target_ff      <= ghs_pkg::RST_BYTE;
        end else begin
            tph_start_ff <= meas_start;
            gas_start_ff <= heat_end; // RULE_14
            if (meas_start) begin
                slot_run_ff    <= slot_sel_ff;
                gas_run_run_ff <= gas_run_ff;
                target_ff      <= sp_ff[slot_sel_ff]; // RULE_01
            end
        end
    end

    // Bang-bang drive while the timer runs; stability judged at the end of heating
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_ff     <= 1'b0;
            stab_meas_ff <= 1'b0;
        end else begin
            drive_ff <= (state_ff == ghs_pkg::ST_HEAT) && heat_busy && below_target; // RULE_02
            if (heat_end) begin
                stab_meas_ff <= !below_target; // RULE_07
            end
        end
    end

    // Results land one cycle before the fresh flag so the host never sees a mix
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gas_adc_ff   <= ghs_pkg::RST_ADC;
            gas_range_ff <= ghs_pkg::RST_RANGE;
            gas_valid_ff <= 1'b0;
            heat_stab_ff <= 1'b0;
            new_data_ff  <= 1'b0;
        end else begin
            if (meas_start) begin
                gas_valid_ff <= 1'b0;
                heat_stab_ff <= 1'b0;
                new_data_ff  <= 1'b0;
            end else if (gas_end) begin
                gas_adc_ff   <= gas_adc_i; // RULE_14
                gas_range_ff <= gas_range_i; // RULE_08
                gas_valid_ff <= 1'b1;
                heat_stab_ff <= stab_meas_ff; // RULE_07
            end else if (state_ff == ghs_pkg::ST_UPDATE) begin
                new_data_ff <= 1'b1; // RULE_05
            end
        end
    end

    ghs_heat_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_heat_timer (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (heat_start),
        .dur_ms_i   (heat_dur),
        .done_o     (heat_done),
        .busy_o     (heat_busy)
    );

    assign reg_rdata_o     = rdata_ff;
    assign tph_start_o     = tph_start_ff;
    assign heater_en_o     = heat_busy; // RULE_15
    assign heater_drive_o  = drive_ff;
    assign heater_target_o = target_ff;
    assign gas_start_o     = gas_start_ff;
    assign new_data_o      = new_data_ff;

    sequence s_gas_finish;
        (state_ff == ghs_pkg::ST_GAS) && gas_done_i;
    endsequence

    sequence s_publish;
        (state_ff == ghs_pkg::ST_UPDATE) ##1 (new_data_o && gas_valid_ff);
    endsequence

    sequence s_short_heat;
        heat_end && below_target;
    endsequence

    a_result_order: assert property (s_gas_finish |=> s_publish) // RULE_14
        else $error("gas result not published before the fresh flag");

    a_heat_in_phase: assert property (heater_en_o |-> state_ff == ghs_pkg::ST_HEAT) // RULE_03
        else $error("heater on outside the heating phase");

    a_heat_after_tph: assert property ($rose(heater_en_o) |-> $past(tph_done_i)) // RULE_03
        else $error("heating started before conversions finished");

    a_drive_below: assert property (heater_drive_o |-> $past(heater_res_i) < heater_target_o) // RULE_02
        else $error("heater driven with resistance at or above target");

    a_stab_cleared: assert property (s_short_heat |=> !stab_meas_ff) // RULE_07
        else $error("heater stable flag set although target was missed");

    a_fresh_cleared: assert property (meas_start |=> !new_data_o) // RULE_05
        else $error("fresh flag not cleared at measurement start");

endmodule

// ==== logic/ghs_heat_timer.sv ====
// Millisecond heating duration timer with one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none

module ghs_heat_timer #(
    parameter int unsigned CYC_PER_MS = ghs_pkg::CYC_PER_MS
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        start_i,
    input  wire logic [11:0] dur_ms_i,
    output logic             done_o,
    output logic             busy_o
);
    localparam int unsigned CW = $clog2(CYC_PER_MS + 1);

    logic [CW-1:0] cyc_ff;
    logic [11:0]   ms_ff;
    logic [11:0]   dur_ff;
    logic [31:0]   elapsed_ff;

    wire ms_tick  = busy_o && (cyc_ff == CW'(CYC_PER_MS - 1));
    wire last_ms  = (ms_ff + 12'h001) == dur_ff;
    wire [11:0] dur_eff = (dur_ms_i == 12'h000) ? ghs_pkg::DUR_MIN_CODE : dur_ms_i;

    if (CYC_PER_MS < 1) begin : g_chk
        $error("CYC_PER_MS must be at least one");
    end

    // Count from heating start; stop on the exact cycle the duration ends
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_ff <= '0;
            ms_ff  <= 12'h000;
            dur_ff <= 12'h000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cyc_ff <= '0;
                ms_ff  <= 12'h000;
                dur_ff <= dur_eff; // RULE_04
                busy_o <= 1'b1;
            end else if (ms_tick) begin
                cyc_ff <= '0;
                if (last_ms) begin
                    busy_o <= 1'b0; // RULE_15
                    done_o <= 1'b1;
                end else begin
                    ms_ff <= ms_ff + 12'h001;
                end
            end else if (busy_o) begin
                cyc_ff <= cyc_ff + CW'(1);
            end
        end
    end

    // Cycle count since start, watched by the checks only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            elapsed_ff <= 32'h0000_0000;
        end else if (start_i) begin
            elapsed_ff <= 32'h0000_0000;
        end else if (busy_o) begin
            elapsed_ff <= elapsed_ff + 32'h0000_0001;
        end
    end

    a_heat_exact_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_15
        done_o |-> elapsed_ff == 32'(dur_ff) * 32'(CYC_PER_MS))
        else $error("heating did not end exactly at the programmed duration");

    a_dur_in_range: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE_04
        busy_o |-> (dur_ff >= 12'(ghs_pkg::DUR_MIN_MS)) && (dur_ff <= 12'(ghs_pkg::DUR_MAX_MS)))
        else $error("heating duration outside 1 to 4032 ms");

endmodule

`default_nettype wire

// ==== testbench/gas_heater_sequencing_readout_tb_top.sv ====
// Testbench for the gas heater sequencer
`timescale 1ns/100ps
`default_nettype none
module gas_heater_sequencing_readout_tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, tst, tdn, en, drv, gst, gdn, nd, seen;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, tgt, res, d;
    logic [9:0] adc = 10'h2A5;
    logic [3:0] rng = 4'h7;
    int n_errors = 0, tests_run = 0, hcnt;
    always #4 clk = ~clk;
    ghs_gas_sequencer #(.CYC_PER_MS(10)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .tph_start_o(tst),
        .tph_done_i(tdn), .heater_en_o(en), .heater_drive_o(drv), .heater_target_o(tgt),
        .heater_res_i(res), .gas_start_o(gst), .gas_done_i(gdn), .gas_adc_i(adc),
        .gas_range_i(rng), .new_data_o(nd));
    ghs_front_model FM (.clk_i(clk), .rst_n_i(rst_n), .tph_start_i(tst), .tph_done_o(tdn),
        .drive_i(drv), .target_i(tgt), .res_o(res), .gas_start_i(gst), .gas_done_o(gdn));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        v = rdata;
    endtask
    task automatic run(input logic [7:0] ctl, input logic [7:0] exp_tgt, input logic [7:0] msb,
                       input logic [7:0] lsb);
        wr_reg(ghs_pkg::ADDR_GAS_CTRL, ctl);
        wr_reg(ghs_pkg::ADDR_MODE, 8'h01);
        hcnt = 0;
        seen = 0;
        repeat (400) begin
            @(negedge clk);
            if (en === 1'b1) begin
                hcnt++;
                chk({7'h0, seen}, 8'h01);
                chk(tgt, exp_tgt);
            end
            if (tdn === 1'b1) seen = 1;
            if (nd === 1'b1) break;
        end
        chk(hcnt[7:0], 8'h0A);
        rd_reg(ghs_pkg::ADDR_STATUS, d);
        chk({7'h0, d[7]}, 8'h01);
        chk({7'h0, d[5]}, 8'h00);
        rd_reg(ghs_pkg::ADDR_GAS_RES_MSB, d);
        chk(d, msb);
        rd_reg(ghs_pkg::ADDR_GAS_RES_LSB, d);
        chk(d, lsb);
        chk({7'h0, d[5]}, 8'h01);
    endtask
    task automatic finish_test;
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200_000;
        n_errors++;
        finish_test;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        rd_reg(8'h00, d);
        chk(d, 8'hF6);
        rd_reg(8'h02, d);
        chk({6'h0, d[5:4]}, 8'h01);
        rd_reg(8'h04, d);
        chk({4'h0, d[7:4]}, 8'h0E);
        wr_reg(8'hEB, 8'hFF);
        rd_reg(8'hEB, d);
        chk(d, 8'hC3);
        rd_reg(8'hEC, d);
        chk(d, 8'hD1);
        rd_reg(8'hED, d);
        chk(d, 8'h9A);
        rd_reg(8'hEE, d);
        chk(d, 8'h12);
        for (int i = 0; i < 10; i++) begin
            wr_reg(8'h10 + 8'(i), 8'h20 + 8'(i));
            wr_reg(8'h20 + 8'(i), 8'h01);
            rd_reg(8'h10 + 8'(i), d);
            chk(d, 8'h20 + 8'(i));
            rd_reg(8'h20 + 8'(i), d);
            chk(d, 8'h01);
        end
        run(8'h19, 8'h29, 8'hA9, 8'h77);
        wr_reg(8'h10, 8'hFF);
        adc = 10'h1C6;
        rng = 4'hB;
        run(8'h10, 8'hFF, 8'h71, 8'hAB);
        finish_test;
    end
endmodule
`default_nettype wire

// ==== testbench/ghs_front_model.sv ====
// Sensor front end model: conversions, hot plate and gas ADC
`timescale 1ns/100ps
`default_nettype none
module ghs_front_model #(parameter logic [7:0] RES_MAX = 8'hC0) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       tph_start_i,
    output logic            tph_done_o,
    input  wire logic       drive_i,
    input  wire logic [7:0] target_i,
    output logic      [7:0] res_o,
    input  wire logic       gas_start_i,
    output logic            gas_done_o
);
    logic [3:0] tph_ff;
    logic [3:0] gas_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tph_ff <= 4'h0;
            gas_ff <= 4'h0;
            res_o <= 8'h00;
        end else begin
            tph_ff <= tph_start_i ? 4'h6 : (tph_ff != 4'h0 ? tph_ff - 4'h1 : 4'h0);
            gas_ff <= gas_start_i ? 4'h3 : (gas_ff != 4'h0 ? gas_ff - 4'h1 : 4'h0);
            // Plate cannot exceed its ceiling
            res_o <= drive_i ? (target_i > RES_MAX ? RES_MAX : target_i) : res_o;
        end
    end
    assign tph_done_o = (tph_ff == 4'h1);
    assign gas_done_o = (gas_ff == 4'h1);
endmodule
`default_nettype wire
